// ==== common/tma_map.vh ====
// register map, field positions, reset values and timing figures of the aux block
`ifndef TMA_MAP_VH
`define TMA_MAP_VH

// ***********************************************************
// register byte offsets
// ***********************************************************
`define TMA_OFS_DIV_A      12'h010
`define TMA_OFS_DIV_B      12'h014
`define TMA_OFS_CTRL       12'h018
`define TMA_OFS_STATUS     12'h01C
`define TMA_OFS_IRQ_STAT   12'h020
`define TMA_OFS_IRQ_MASK   12'h024

// ***********************************************************
// field positions
// ***********************************************************
`define TMA_DIV_CAL_LSB    0
`define TMA_DIV_PLL_LSB    3
`define TMA_DIV_MTR_LSB    0
`define TMA_CTRL_MODE_LSB  0
`define TMA_CTRL_FCLR_BIT  2
`define TMA_CTRL_ISRC_BIT  7
`define TMA_ST_FLAG_BIT    0
`define TMA_ST_ACT_BIT     1
`define TMA_ST_G1_BIT      2
`define TMA_ST_G2_BIT      3
`define TMA_ST_CNT1_LSB    8
`define TMA_ST_CNT2_LSB    16
`define TMA_EV_RESULT      0
`define TMA_EV_OVF         1
`define TMA_EV_STOP_INPUT_CH1       2
`define TMA_EV_STOP_INPUT_CH2       3
`define TMA_EV_GFAULT      4
`define TMA_EV_W           5

// ***********************************************************
// modes and reset values
// ***********************************************************
`define TMA_MODE_SHORT     2'h0
`define TMA_MODE_LONG      2'h1
`define TMA_MODE_RESADJ    2'h2
`define TMA_DIV_A_RST      6'h00
`define TMA_DIV_B_RST      3'h0
`define TMA_CTRL_RST       8'h00
`define TMA_MASK_RST       5'h00

// ***********************************************************
// divider figures
// ***********************************************************
`define TMA_DIV_CNT_W      7
`define TMA_DIV_MAX_CODE   3'h6
`define TMA_DIV_CAP_CODE   3'h5

`endif

// ==== src/tma_sync.v ====
// two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module tma_sync (
  input  wire clk_sys_in,
  input  wire rst_n_in,
  input  wire async_in,
  output reg  sync_out
);
  reg meta_q;

  // first stage is read only by the second
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== src/tma_clk_div.v ====
// power-of-two divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "tma_map.vh"
module tma_clk_div #(
  parameter CAP_AT_SIX = 0
) (
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire [2:0] sel_in,
  output reg        en_out
);
  reg  [2:0]                sel_q;
  reg  [`TMA_DIV_CNT_W-1:0] cnt_q;
  reg  [2:0]                shift;
  wire [`TMA_DIV_CNT_W-1:0] last;

  // codes 6 and 7 give 64, the capped variant gives 32 at code 6
  always @* begin
    if (sel_in > `TMA_DIV_MAX_CODE)
      shift = `TMA_DIV_MAX_CODE;
    else if ((CAP_AT_SIX != 0) && (sel_in == `TMA_DIV_MAX_CODE))
      shift = `TMA_DIV_CAP_CODE;
    else
      shift = sel_in;
  end
  assign last = (7'h01 << shift) - 7'h01;

  // count restarts when the select changes, so a write acts at once
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_q  <= 3'h0;
      cnt_q  <= 7'h00;
      en_out <= 1'b0;
    end else begin
      sel_q <= sel_in;
      if (sel_in != sel_q) begin
        cnt_q  <= 7'h00;
        en_out <= 1'b0;
      end else if (cnt_q >= last) begin
        cnt_q  <= 7'h00;
        en_out <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 7'h01;
        en_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/tma_top.v ====
// auxiliary functions of a two-channel time-interval measuring unit
//
// Summary of operation
// - each stop gate high enables its channel
// - start is accepted whatever the gates show
// - flag source: result written or overflow
// - control bit 7 selects source, reset result
// - interrupt event shows as flag rising edge
// - three derived clocks, each own divider
// - codes 0..5 give 1..32, 6/7 give 64 (meter clock: 6 gives 32)
// - divider selects live in two registers
`timescale 1ns/1ps
`default_nettype none
`include "tma_map.vh"
module tma_top (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // measurement pins
  input  wire        start_input_in,
  input  wire        stop_input_ch1_in,
  input  wire        stop_input_ch2_in,
  input  wire        stop_gate_ch1_in,
  input  wire        stop_gate_ch2_in,
  // events from the measuring core on this clock
  input  wire        result_written_in,
  input  wire        overflow_in,
  // accepted edges towards the measuring core
  output reg         start_accept_out,
  output reg         stop_accept_ch1_out,
  output reg         stop_accept_ch2_out,
  // derived clock enables
  output wire        calib_clk_en_out,
  output wire        pll_ref_en_out,
  output wire        meter_clk_en_out,
  // flags
  output reg         interrupt_flag_out,
  output wire        irq_out
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  wire                  start_s;
  wire                  stop_input_ch1_s;
  wire                  stop_input_ch2_s;
  wire                  gate1_s;
  wire                  gate2_s;
  reg                   start_d1_q;
  reg                   stop_input_ch1_d1_q;
  reg                   stop_input_ch2_d1_q;
  reg                   gate1_d1_q;
  reg                   gate2_d1_q;
  wire                  start_rise;
  wire                  stop_input_ch1_rise;
  wire                  stop_input_ch2_rise;
  reg                   gate_ok1;
  reg                   gate_ok2;
  reg  [5:0]            div_a_q;
  reg  [2:0]            div_b_q;
  reg  [7:0]            ctrl_q;
  reg  [`TMA_EV_W-1:0]  irq_stat_q;
  reg  [`TMA_EV_W-1:0]  irq_stat_d;
  reg  [`TMA_EV_W-1:0]  irq_mask_q;
  reg  [`TMA_EV_W-1:0]  events;
  reg                   active_q;
  reg  [7:0]            cnt1_q;
  reg  [7:0]            cnt2_q;
  reg                   flag_src;
  reg                   flag_clr;
  reg                   gate_fault;
  wire [1:0]            mode;
  wire                  wr_en;
  wire                  rd_setup;
  reg                   addr_ok;
  reg  [31:0]           rd_mux;
  reg  [31:0]           status_w;

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  tma_sync u_sync_start (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (start_input_in),
    .sync_out   (start_s)
  );
  tma_sync u_sync_stop_input_ch1 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (stop_input_ch1_in),
    .sync_out   (stop_input_ch1_s)
  );
  tma_sync u_sync_stop_input_ch2 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (stop_input_ch2_in),
    .sync_out   (stop_input_ch2_s)
  );
  tma_sync u_sync_gate1 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (stop_gate_ch1_in),
    .sync_out   (gate1_s)
  );
  tma_sync u_sync_gate2 (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (stop_gate_ch2_in),
    .sync_out   (gate2_s)
  );

  // ***********************************************************
  // edge detection on synchronised pins
  // ***********************************************************
  // one more stage gives the previous level of each pin
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_d1_q <= 1'b0;
      stop_input_ch1_d1_q <= 1'b0;
      stop_input_ch2_d1_q <= 1'b0;
      gate1_d1_q <= 1'b0;
      gate2_d1_q <= 1'b0;
    end else begin
      start_d1_q <= start_s;
      stop_input_ch1_d1_q <= stop_input_ch1_s;
      stop_input_ch2_d1_q <= stop_input_ch2_s;
      gate1_d1_q <= gate1_s;
      gate2_d1_q <= gate2_s;
    end
  end

  assign start_rise = start_s & ~start_d1_q;
  assign stop_input_ch1_rise = stop_input_ch1_s & ~stop_input_ch1_d1_q;
  assign stop_input_ch2_rise = stop_input_ch2_s & ~stop_input_ch2_d1_q;
  assign mode       = ctrl_q[`TMA_CTRL_MODE_LSB+1:`TMA_CTRL_MODE_LSB];

  // ***********************************************************
  // stop gating
  // ***********************************************************
  // short and adjust modes want the gate high before and at the edge;
  // long range only looks at the gate level at the edge
  always @* begin
    if (mode == `TMA_MODE_LONG) begin
      gate_ok1 = gate1_s;
      gate_ok2 = gate2_s;
    end else begin
      gate_ok1 = gate1_s & gate1_d1_q;
      gate_ok2 = gate2_s & gate2_d1_q;
    end
  end

  // gates low during a long-range measurement break the far side's duty
  always @* begin
    gate_fault = active_q & (mode == `TMA_MODE_LONG) & ~(gate1_s & gate2_s);
  end

  // accepted edges as registered one-cycle pulses
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_accept_out    <= 1'b0;
      stop_accept_ch1_out <= 1'b0;
      stop_accept_ch2_out <= 1'b0;
    end else begin
      start_accept_out    <= start_rise;
      stop_accept_ch1_out <= stop_input_ch1_rise & gate_ok1;
      stop_accept_ch2_out <= stop_input_ch2_rise & gate_ok2;
    end
  end

  // ***********************************************************
  // measurement tracking
  // ***********************************************************
  // start opens a measurement and clears the hit counts, a result or an overflow closes it
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_q <= 1'b0;
      cnt1_q   <= 8'h00;
      cnt2_q   <= 8'h00;
    end else begin
      if (start_accept_out) begin
        active_q <= 1'b1;
      end else if (result_written_in | overflow_in) begin
        active_q <= 1'b0;
      end
      if (start_accept_out) begin
        cnt1_q <= 8'h00;
      end else if (stop_accept_ch1_out && cnt1_q != 8'hFF) begin
        cnt1_q <= cnt1_q + 8'h01;
      end
      if (start_accept_out) begin
        cnt2_q <= 8'h00;
      end else if (stop_accept_ch2_out && cnt2_q != 8'hFF) begin
        cnt2_q <= cnt2_q + 8'h01;
      end
    end
  end

  // ***********************************************************
  // interrupt flag pin
  // ***********************************************************
  // the selected source sets the flag; a new start or software clears it
  always @* begin
    if (ctrl_q[`TMA_CTRL_ISRC_BIT])
      flag_src = overflow_in;
    else
      flag_src = result_written_in;
    flag_clr = start_accept_out |
               (wr_en && paddr_in == `TMA_OFS_CTRL && pwdata_in[`TMA_CTRL_FCLR_BIT]);
  end

  // set wins over clear so an event is never lost
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_flag_out <= 1'b0;
    end else if (flag_src) begin
      interrupt_flag_out <= 1'b1;
    end else if (flag_clr) begin
      interrupt_flag_out <= 1'b0;
    end
  end

  // ***********************************************************
  // derived clock dividers
  // ***********************************************************
  tma_clk_div #(
    .CAP_AT_SIX (0)
  ) u_div_cal (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     (div_a_q[`TMA_DIV_CAL_LSB+2:`TMA_DIV_CAL_LSB]),
    .en_out     (calib_clk_en_out)
  );
  tma_clk_div #(
    .CAP_AT_SIX (0)
  ) u_div_pll (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     (div_a_q[`TMA_DIV_PLL_LSB+2:`TMA_DIV_PLL_LSB]),
    .en_out     (pll_ref_en_out)
  );
  tma_clk_div #(
    .CAP_AT_SIX (1)
  ) u_div_mtr (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     (div_b_q[`TMA_DIV_MTR_LSB+2:`TMA_DIV_MTR_LSB]),
    .en_out     (meter_clk_en_out)
  );

  // ***********************************************************
  // apb decode
  // ***********************************************************
  assign wr_en       = psel_in & penable_in & pwrite_in & addr_ok;
  assign rd_setup    = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // address check and read data selection
  always @* begin
    status_w = 32'h0000_0000;
    status_w[`TMA_ST_FLAG_BIT] = interrupt_flag_out;
    status_w[`TMA_ST_ACT_BIT]  = active_q;
    status_w[`TMA_ST_G1_BIT]   = gate1_s;
    status_w[`TMA_ST_G2_BIT]   = gate2_s;
    status_w[`TMA_ST_CNT1_LSB+7:`TMA_ST_CNT1_LSB] = cnt1_q;
    status_w[`TMA_ST_CNT2_LSB+7:`TMA_ST_CNT2_LSB] = cnt2_q;
    addr_ok = 1'b1;
    case (paddr_in)
      `TMA_OFS_DIV_A:    rd_mux = {26'h0, div_a_q};
      `TMA_OFS_DIV_B:    rd_mux = {29'h0, div_b_q};
      `TMA_OFS_CTRL:     rd_mux = {24'h0, ctrl_q};
      `TMA_OFS_STATUS:   rd_mux = status_w;
      `TMA_OFS_IRQ_STAT: rd_mux = {27'h0, irq_stat_q};
      `TMA_OFS_IRQ_MASK: rd_mux = {27'h0, irq_mask_q};
      default: begin
        rd_mux  = 32'h0000_0000;
        addr_ok = 1'b0;
      end
    endcase
  end

  // read data is captured in the setup cycle and stands for the access
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_out <= rd_mux;
    end
  end

  // ***********************************************************
  // control registers
  // ***********************************************************
  // flag clear bit is a strobe and never stored
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_a_q    <= `TMA_DIV_A_RST;
      div_b_q    <= `TMA_DIV_B_RST;
      ctrl_q     <= `TMA_CTRL_RST;
      irq_mask_q <= `TMA_MASK_RST;
    end else if (wr_en) begin
      case (paddr_in)
        `TMA_OFS_DIV_A:    div_a_q    <= pwdata_in[5:0];
        `TMA_OFS_DIV_B:    div_b_q    <= pwdata_in[2:0];
        `TMA_OFS_CTRL:     ctrl_q     <= pwdata_in[7:0] &
                                         ~(8'h01 << `TMA_CTRL_FCLR_BIT);
        `TMA_OFS_IRQ_MASK: irq_mask_q <= pwdata_in[`TMA_EV_W-1:0];
        default:           ctrl_q     <= ctrl_q;
      endcase
    end
  end

  // ***********************************************************
  // interrupt status
  // ***********************************************************
  // events set sticky bits; write one clears, a new event wins
  always @* begin
    events = {`TMA_EV_W{1'b0}};
    events[`TMA_EV_RESULT] = result_written_in;
    events[`TMA_EV_OVF]    = overflow_in;
    events[`TMA_EV_STOP_INPUT_CH1]  = stop_accept_ch1_out;
    events[`TMA_EV_STOP_INPUT_CH2]  = stop_accept_ch2_out;
    events[`TMA_EV_GFAULT] = gate_fault;
    irq_stat_d = irq_stat_q;
    if (wr_en && paddr_in == `TMA_OFS_IRQ_STAT)
      irq_stat_d = irq_stat_q & ~pwdata_in[`TMA_EV_W-1:0];
    irq_stat_d = irq_stat_d | events;
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= {`TMA_EV_W{1'b0}};
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// ==== verification/tma_checker.sv ====
// port-level assertion checker for the aux block
`timescale 1ns/1ps
`default_nettype none
`include "tma_map.vh"
module tma_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        start_input_in,
  input wire logic        stop_input_ch1_in,
  input wire logic        stop_input_ch2_in,
  input wire logic        stop_gate_ch1_in,
  input wire logic        stop_gate_ch2_in,
  input wire logic        result_written_in,
  input wire logic        overflow_in,
  input wire logic        start_accept_out,
  input wire logic        stop_accept_ch1_out,
  input wire logic        stop_accept_ch2_out,
  input wire logic        calib_clk_en_out,
  input wire logic        pll_ref_en_out,
  input wire logic        meter_clk_en_out,
  input wire logic        interrupt_flag_out
);
  // ***********************************************************
  // shadow of source bit and divider period counters
  // ***********************************************************
  wire logic       wr_w = psel_in & penable_in & pwrite_in;
  wire logic [2:0] en_w = {meter_clk_en_out, pll_ref_en_out, calib_clk_en_out};
  reg              isrc_q;
  reg        [2:0] sel_q  [0:2];
  reg        [6:0] cnt_q  [0:2];
  reg        [1:0] seen_q [0:2];
  function automatic [6:0] fac(input [2:0] c, input m);
    fac = (m && c == 3'h6) ? 7'h20 : (7'h01 << ((c == 3'h7) ? 3'h6 : c));
  endfunction
  // period is only trusted after two pulses since the last select write
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      isrc_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        sel_q[i]  <= 3'h0;
        cnt_q[i]  <= 7'h00;
        seen_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= en_w[i] ? 7'h00 : cnt_q[i] + 7'h01;
        if (en_w[i] && seen_q[i] != 2'h3) begin
          seen_q[i] <= seen_q[i] + 2'h1;
        end
      end
      if (wr_w && paddr_in == `TMA_OFS_CTRL) begin
        isrc_q <= pwdata_in[`TMA_CTRL_ISRC_BIT];
      end
      if (wr_w && paddr_in == `TMA_OFS_DIV_A) begin
        sel_q[0]  <= pwdata_in[2:0];
        sel_q[1]  <= pwdata_in[5:3];
        seen_q[0] <= 2'h0;
        seen_q[1] <= 2'h0;
      end
      if (wr_w && paddr_in == `TMA_OFS_DIV_B) begin
        sel_q[2]  <= pwdata_in[2:0];
        seen_q[2] <= 2'h0;
      end
    end
  end
  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_start_free: assert property ($rose(start_input_in) |-> ##3 start_accept_out)
    else $error("start edge not accepted");
  chk_stop_gated: assert property (stop_accept_ch1_out |-> $past(stop_gate_ch1_in, 3))
    else $error("stop accepted with gate low");
  chk_stop_pass: assert property ($rose(stop_input_ch2_in) && stop_gate_ch2_in &&
    $past(stop_gate_ch2_in, 6) |-> ##[3:5] stop_accept_ch2_out) else $error("gated stop lost");
  chk_flag_result: assert property (!isrc_q && result_written_in |=> interrupt_flag_out)
    else $error("result event did not raise flag");
  chk_flag_ovf: assert property (isrc_q && overflow_in |=> interrupt_flag_out)
    else $error("overflow event did not raise flag");
  chk_flag_cause: assert property ($rose(interrupt_flag_out) |->
    $past(isrc_q ? overflow_in : result_written_in)) else $error("flag rose without event");
  chk_div_cal: assert property (seen_q[0][1] |-> cnt_q[0] < fac(sel_q[0], 1'b0) &&
    (en_w[0] == (cnt_q[0] == fac(sel_q[0], 1'b0) - 7'h01))) else $error("calib period wrong");
  chk_div_pll: assert property (seen_q[1][1] |-> cnt_q[1] < fac(sel_q[1], 1'b0) &&
    (en_w[1] == (cnt_q[1] == fac(sel_q[1], 1'b0) - 7'h01))) else $error("pll period wrong");
  chk_div_mtr: assert property (seen_q[2][1] |-> cnt_q[2] < fac(sel_q[2], 1'b1) &&
    (en_w[2] == (cnt_q[2] == fac(sel_q[2], 1'b1) - 7'h01))) else $error("meter period wrong");
  cov_flag: cover property ($rose(interrupt_flag_out));
  cov_stop_drop: cover property ($rose(stop_input_ch1_in) && !stop_gate_ch1_in);
  cov_div_top: cover property (seen_q[1][1] && sel_q[1] == 3'h7 && pll_ref_en_out);
endmodule
`default_nettype wire

// ==== verification/tma_pin_partner.sv ====
// pin-side partner: drives gates and edges, watches the flag
`timescale 1ns/1ps
`default_nettype none
module tma_pin_partner (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic interrupt_flag_in,
  output var  logic start_out,
  output var  logic stop_ch1_out,
  output var  logic stop_ch2_out,
  output var  logic gate_ch1_out,
  output var  logic gate_ch2_out
);
  int   flag_rises = 0;
  logic flag_q;
  initial begin
    {stop_ch2_out, stop_ch1_out, start_out} = 3'h0;
    {gate_ch2_out, gate_ch1_out} = 2'h0;
  end
  // readout trigger on each flag rising edge
  always @(posedge clk_sys_in) begin
    flag_q <= interrupt_flag_in;
    if (rst_n_in && interrupt_flag_in && !flag_q) begin
      flag_rises <= flag_rises + 1;
    end
  end
  // edges high and low three cycles each, gates set with them
  task automatic pulse(input logic [2:0] pins, input logic [1:0] gates);
    {stop_ch2_out, stop_ch1_out, start_out} <= pins;
    {gate_ch2_out, gate_ch1_out} <= gates;
    repeat (3) @(posedge clk_sys_in);
    {stop_ch2_out, stop_ch1_out, start_out} <= 3'h0;
    repeat (3) @(posedge clk_sys_in);
  endtask
  // long range: both gates stay high from before start to the end
  task automatic long_run();
    pulse(3'h0, 2'h3);
    pulse(3'h1, 2'h3);
    pulse(3'h6, 2'h3);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the aux block
`timescale 1ns/1ps
`default_nettype none
`include "tma_map.vh"
module tb;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        psel, penable, pwrite, res_wr, ovf, pready, perr;
  logic        st, s1, s2, g1, g2, flag, irq, acc0, acc1, acc2, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  en;
  int          mismatches, comparisons, p, g, c;
  int          n_acc[3] = '{0, 0, 0};
  int          x[3];
  always #2.5 clk_sys_in = ~clk_sys_in;
  tma_top tma_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .start_input_in(st),
    .stop_input_ch1_in(s1), .stop_input_ch2_in(s2), .stop_gate_ch1_in(g1),
    .stop_gate_ch2_in(g2), .result_written_in(res_wr), .overflow_in(ovf),
    .start_accept_out(acc0), .stop_accept_ch1_out(acc1), .stop_accept_ch2_out(acc2),
    .calib_clk_en_out(en[0]), .pll_ref_en_out(en[1]), .meter_clk_en_out(en[2]),
    .interrupt_flag_out(flag), .irq_out(irq));
  tma_pin_partner tma_pin_partner_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .interrupt_flag_in(flag), .start_out(st), .stop_ch1_out(s1), .stop_ch2_out(s2),
    .gate_ch1_out(g1), .gate_ch2_out(g2));
  // count accepted edges
  always @(posedge clk_sys_in) begin
    if (rst_n_in) begin
      n_acc[0] <= n_acc[0] + int'(acc0);
      n_acc[1] <= n_acc[1] + int'(acc1);
      n_acc[2] <= n_acc[2] + int'(acc2);
    end
  end
  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic test_done();
    $display("counts: %0d compared, %0d bad", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic int fac(input logic [2:0] cd, input bit m);
    return (m && cd == 3'h6) ? 32 : 1 << ((cd == 3'h7) ? 6 : cd);
  endfunction
  // one apb transfer, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    @(posedge clk_sys_in);
  endtask
  // spacing between the second and third enable pulse
  task automatic period(input int i);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(posedge clk_sys_in);
        p++;
      end while (en[i] !== 1'b1 && p < 300);
      if (p >= 300) begin
        mismatches++;
        test_done();
      end
    end
  endtask
  task automatic ev(input bit o);
    if (o) ovf <= 1'b1;
    else res_wr <= 1'b1;
    @(posedge clk_sys_in);
    ovf    <= 1'b0;
    res_wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {psel, penable, pwrite, res_wr, ovf} = 5'h00;
    paddr  = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'hA9A6E76C));
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int a = 'h10; a <= 'h24; a += 4) begin
      apb(1'b0, a[11:0], 32'h0);
      chk(rd, 32'h0);
      chk(e, 1'b0);
    end
    apb(1'b0, 12'h0FC, 32'h0);
    chk(rd, 32'h0);
    chk(e, 1'b1);
    $display("done: reset and unmapped");
    for (int k = 0; k < 10; k++) begin
      c = (k < 8) ? k : $urandom_range(7);
      g = 7 - c;
      apb(1'b1, `TMA_OFS_DIV_A, {26'h0, g[2:0], c[2:0]});
      apb(1'b1, `TMA_OFS_DIV_B, {29'h0, c[2:0]});
      period(0);
      chk(p, fac(c[2:0], 1'b0));
      period(1);
      chk(p, fac(g[2:0], 1'b0));
      period(2);
      chk(p, fac(c[2:0], 1'b1));
    end
    $display("done: dividers");
    x = n_acc;
    for (int k = 0; k < 10; k++) begin
      g = (k > 5) ? 9 - k : $urandom_range(3);
      tma_pin_partner_inst.pulse(3'h0, g[1:0]);
      tma_pin_partner_inst.pulse(3'h1, g[1:0]);
      tma_pin_partner_inst.pulse(3'h6, g[1:0]);
      x[0]++;
      x[1] += g[0];
      x[2] += g[1];
      apb(1'b0, `TMA_OFS_STATUS, 32'h0);
      chk(rd, {15'h0, g[1], 7'h0, g[0], 4'h0, g[1:0], 2'h2});
    end
    apb(1'b1, `TMA_OFS_CTRL, 32'h02);
    tma_pin_partner_inst.pulse(3'h6, 2'h3);
    chk(n_acc[1], x[1]);
    ev(1'b1);
    apb(1'b1, `TMA_OFS_CTRL, 32'h01);
    tma_pin_partner_inst.pulse(3'h0, 2'h0);
    tma_pin_partner_inst.pulse(3'h6, 2'h3);
    chk(n_acc[0], x[0]);
    chk(n_acc[1], x[1] + 1);
    chk(n_acc[2], x[2] + 1);
    $display("done: gating");
    apb(1'b1, `TMA_OFS_IRQ_STAT, 32'h1F);
    apb(1'b1, `TMA_OFS_IRQ_MASK, 32'h04);
    chk(irq, 1'b0);
    tma_pin_partner_inst.pulse(3'h2, 2'h1);
    chk(irq, 1'b1);
    apb(1'b0, `TMA_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h04);
    apb(1'b1, `TMA_OFS_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, `TMA_OFS_IRQ_MASK, 32'h04);
    chk(irq, 1'b1);
    apb(1'b1, `TMA_OFS_IRQ_STAT, 32'h04);
    chk(irq, 1'b0);
    $display("done: interrupt");
    apb(1'b1, `TMA_OFS_CTRL, 32'h00);
    ev(1'b0);
    chk(flag, 1'b1);
    apb(1'b1, `TMA_OFS_CTRL, 32'h04);
    chk(flag, 1'b0);
    ev(1'b1);
    chk(flag, 1'b0);
    apb(1'b1, `TMA_OFS_CTRL, 32'h80);
    ev(1'b0);
    chk(flag, 1'b0);
    ev(1'b1);
    chk(flag, 1'b1);
    tma_pin_partner_inst.pulse(3'h1, 2'h0);
    chk(flag, 1'b0);
    chk(tma_pin_partner_inst.flag_rises, 2);
    ev(1'b0);
    $display("done: flag");
    apb(1'b1, `TMA_OFS_CTRL, 32'h01);
    apb(1'b1, `TMA_OFS_IRQ_STAT, 32'h1F);
    tma_pin_partner_inst.long_run();
    ev(1'b0);
    apb(1'b0, `TMA_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0D);
    tma_pin_partner_inst.pulse(3'h1, 2'h2);
    ev(1'b1);
    apb(1'b0, `TMA_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h1F);
    $display("done: long range");
    test_done();
  end
endmodule
bind tma_top tma_checker tma_checker_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .start_input_in(start_input_in),
  .stop_input_ch1_in(stop_input_ch1_in), .stop_input_ch2_in(stop_input_ch2_in),
  .stop_gate_ch1_in(stop_gate_ch1_in), .stop_gate_ch2_in(stop_gate_ch2_in),
  .result_written_in(result_written_in), .overflow_in(overflow_in),
  .start_accept_out(start_accept_out), .stop_accept_ch1_out(stop_accept_ch1_out),
  .stop_accept_ch2_out(stop_accept_ch2_out), .calib_clk_en_out(calib_clk_en_out),
  .pll_ref_en_out(pll_ref_en_out), .meter_clk_en_out(meter_clk_en_out),
  .interrupt_flag_out(interrupt_flag_out));
`default_nettype wire
